// ==== src/gp_port_bank.sv ====
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps

// Behaviour
// (RULE1) seven independent ports, A through G
// (RULE2) output may change every clock
// (RULE3) edge or level interrupt sense, per-pin mask
// (RULE4) data access masked by address bits
// (RULE5) digital enable clear disconnects digital paths
// (RULE6) afsel, digital enable, mux code route peripheral
// (RULE7) function select independent for each pin
// (RULE8) other pins reset to tri-stated gpio
// (RULE9) reset restores every pin default
// (RULE10) port A and C non-zero defaults
// (RULE11) drive strength, pulls, open drain, slew
// (RULE12) address bits 9:2 form data mask
// (RULE13) direction selects capture or drive
// (RULE14) edge interrupt sticky until cleared; one per port
// (RULE15) pin inputs synchronised before use
// (RULE16) disabled pin reads zero, no interrupt
module gp_port_bank
   import gp_pkg::*;
(
   input  logic                                        clk_i,
   input  logic                                        reset_i,
   input  logic [GP_ADDR_W-1:0]                        addr_i,
   input  logic [31:0]                                 wdata_i,
   input  logic                                        wr_i,
   input  logic                                        rd_i,
   output logic [31:0]                                 rdata_o,
   output logic [GP_PORTS-1:0]                         irq_o,
   input  logic [GP_PORTS-1:0][GP_PINS-1:0]            pin_in_i,
   output logic [GP_PORTS-1:0][GP_PINS-1:0]            pin_out_o,
   output logic [GP_PORTS-1:0][GP_PINS-1:0]            pin_oe_o,
   input  logic [GP_PORTS-1:0][GP_PINS-1:0][GP_ALT_N-1:0] alt_out_i,
   input  logic [GP_PORTS-1:0][GP_PINS-1:0][GP_ALT_N-1:0] alt_oe_i,
   output logic [GP_PORTS-1:0][GP_PINS-1:0]            alt_in_o,
   output gp_pad_t [GP_PORTS-1:0]                      pad_o
);

   // ==========================================================
   // state
   gp_state_t st_ff;
   gp_state_t nxt_st;

   logic [2:0]  sel_port;
   logic [11:0] ofs;
   logic [7:0]  amask;

   assign sel_port = addr_i[GP_PSEL_HI:GP_PSEL_LO];
   assign ofs      = {addr_i[11:2], 2'b00};
   assign amask    = addr_i[GP_MASK_HI:GP_MASK_LO];  // [RULE12]

   // ==========================================================
   // next state
   always_comb begin
      logic [7:0] rise;
      logic [7:0] fall;
      logic [7:0] edge_ev;
      logic [7:0] lvl_ev;
      logic [7:0] clr;
      logic [7:0] w8;
      logic       hit;
      rise    = '0;
      fall    = '0;
      edge_ev = '0;
      lvl_ev  = '0;
      clr     = '0;
      w8      = wdata_i[7:0];
      hit     = 1'b0;
      nxt_st  = st_ff;
      nxt_st.rdata = '0;
      for (int p = 0; p < GP_PORTS; p++) begin  // [RULE1]
         hit = (sel_port == 3'(p));
         // first stage feeds only the second
         nxt_st.port[p].sync1 = pin_in_i[p];  // [RULE15]
         nxt_st.port[p].sync2 = st_ff.port[p].sync1;
         nxt_st.port[p].prev  = st_ff.port[p].sync2;
         // inputs captured into the data register
         nxt_st.port[p].data = (st_ff.port[p].data & st_ff.port[p].dir)
                             | (st_ff.port[p].sync2 & ~st_ff.port[p].dir);  // [RULE13]

         // interrupt detection on synchronised, enabled pins
         rise    = st_ff.port[p].sync2 & ~st_ff.port[p].prev;
         fall    = ~st_ff.port[p].sync2 & st_ff.port[p].prev;
         edge_ev = (st_ff.port[p].iboth & (rise | fall))
                 | (~st_ff.port[p].iboth & st_ff.port[p].ievent & rise)
                 | (~st_ff.port[p].iboth & ~st_ff.port[p].ievent & fall);  // [RULE3]
         lvl_ev  = (st_ff.port[p].ievent & st_ff.port[p].sync2)
                 | (~st_ff.port[p].ievent & ~st_ff.port[p].sync2);  // [RULE3]
         clr     = (wr_i && hit && ofs == GP_OFS_ICLR) ? w8 : 8'h00;
         // set wins over a clear in the same cycle
         nxt_st.port[p].rawst = st_ff.port[p].digital_enable_reg
                              & ((st_ff.port[p].isense & lvl_ev)
                              | (~st_ff.port[p].isense
                                 & ((st_ff.port[p].rawst & ~clr) | edge_ev)));  // [RULE14] [RULE16]

         // register writes
         if (wr_i && hit) begin
            if (ofs <= GP_OFS_DATA_LAST) begin
               // only driven bits keep a written value
               nxt_st.port[p].data = (nxt_st.port[p].data & ~(amask & st_ff.port[p].dir))
                                   | (w8 & amask & st_ff.port[p].dir);  // [RULE4] [RULE12] [RULE2]
            end else if (ofs == GP_OFS_DIR) begin
               nxt_st.port[p].dir = w8;
            end else if (ofs == GP_OFS_ISENSE) begin
               nxt_st.port[p].isense = w8;
            end else if (ofs == GP_OFS_IBOTH) begin
               nxt_st.port[p].iboth = w8;
            end else if (ofs == GP_OFS_IEVENT) begin
               nxt_st.port[p].ievent = w8;
            end else if (ofs == GP_OFS_IMASK) begin
               nxt_st.port[p].imask = w8;  // [RULE3]
            end else if (ofs == GP_OFS_AFSEL) begin
               nxt_st.port[p].afsel = w8;  // [RULE6]
            end else if (ofs == GP_OFS_DR2) begin
               // at most one drive select is set per pin
               nxt_st.port[p].dr2 = w8;  // [RULE11]
               nxt_st.port[p].dr4 = st_ff.port[p].dr4 & ~w8;
               nxt_st.port[p].dr8 = st_ff.port[p].dr8 & ~w8;
            end else if (ofs == GP_OFS_DR4) begin
               nxt_st.port[p].dr4 = w8;  // [RULE11]
               nxt_st.port[p].dr2 = st_ff.port[p].dr2 & ~w8;
               nxt_st.port[p].dr8 = st_ff.port[p].dr8 & ~w8;
            end else if (ofs == GP_OFS_DR8) begin
               nxt_st.port[p].dr8 = w8;  // [RULE11]
               nxt_st.port[p].dr2 = st_ff.port[p].dr2 & ~w8;
               nxt_st.port[p].dr4 = st_ff.port[p].dr4 & ~w8;
            end else if (ofs == GP_OFS_ODR) begin
               nxt_st.port[p].odr = w8;
            end else if (ofs == GP_OFS_PUR) begin
               // pulls are exclusive per pin
               nxt_st.port[p].pur = w8;  // [RULE11]
               nxt_st.port[p].pdr = st_ff.port[p].pdr & ~w8;
            end else if (ofs == GP_OFS_PDR) begin
               nxt_st.port[p].pdr = w8;  // [RULE11]
               nxt_st.port[p].pur = st_ff.port[p].pur & ~w8;
            end else if (ofs == GP_OFS_SLR) begin
               nxt_st.port[p].slr = w8;
            end else if (ofs == GP_OFS_DIG_EN) begin
               nxt_st.port[p].digital_enable_reg = w8;  // [RULE5]
            end else if (ofs == GP_OFS_PCTL) begin
               nxt_st.port[p].pctl = wdata_i;  // [RULE6]
            end
         end

         // register reads, answered the next cycle
         if (rd_i && hit) begin
            if (ofs <= GP_OFS_DATA_LAST) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].data & st_ff.port[p].digital_enable_reg
                               & amask};  // [RULE4] [RULE16]
            end else if (ofs == GP_OFS_DIR) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].dir};
            end else if (ofs == GP_OFS_ISENSE) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].isense};
            end else if (ofs == GP_OFS_IBOTH) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].iboth};
            end else if (ofs == GP_OFS_IEVENT) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].ievent};
            end else if (ofs == GP_OFS_IMASK) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].imask};
            end else if (ofs == GP_OFS_RAWST) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].rawst};
            end else if (ofs == GP_OFS_MSKST) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].rawst & st_ff.port[p].imask};
            end else if (ofs == GP_OFS_AFSEL) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].afsel};
            end else if (ofs == GP_OFS_DR2) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].dr2};
            end else if (ofs == GP_OFS_DR4) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].dr4};
            end else if (ofs == GP_OFS_DR8) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].dr8};
            end else if (ofs == GP_OFS_ODR) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].odr};
            end else if (ofs == GP_OFS_PUR) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].pur};
            end else if (ofs == GP_OFS_PDR) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].pdr};
            end else if (ofs == GP_OFS_SLR) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].slr};
            end else if (ofs == GP_OFS_DIG_EN) begin
               nxt_st.rdata = {24'h0, st_ff.port[p].digital_enable_reg};
            end else if (ofs == GP_OFS_PCTL) begin
               nxt_st.rdata = st_ff.port[p].pctl;
            end
         end
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_ff <= GP_RST_STATE;  // [RULE8] [RULE9] [RULE10]
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata_o = st_ff.rdata;

   // ==========================================================
   // pin and peripheral routing
   always_comb begin
      logic [GP_MUX_W-1:0] code;
      logic                drv;
      logic                en;
      code      = '0;
      drv       = 1'b0;
      en        = 1'b0;
      pin_out_o = '0;
      pin_oe_o  = '0;
      alt_in_o  = '0;
      for (int p = 0; p < GP_PORTS; p++) begin
         irq_o[p] = |(st_ff.port[p].rawst & st_ff.port[p].imask);  // [RULE14] [RULE3]
         pad_o[p].pull_up    = st_ff.port[p].pur;
         pad_o[p].pull_down  = st_ff.port[p].pdr;
         pad_o[p].open_drain = st_ff.port[p].odr;
         pad_o[p].drive_2ma  = st_ff.port[p].dr2;
         pad_o[p].drive_4ma  = st_ff.port[p].dr4;
         pad_o[p].drive_8ma  = st_ff.port[p].dr8;
         pad_o[p].slew_ctl   = st_ff.port[p].slr & st_ff.port[p].dr8;  // [RULE11]
         pad_o[p].analog_sel = ~st_ff.port[p].digital_enable_reg;  // [RULE5]
         for (int i = 0; i < GP_PINS; i++) begin
            // each pin reads only its own mux code
            code = st_ff.port[p].pctl[i*GP_MUX_W +: GP_MUX_W];  // [RULE7]
            if (st_ff.port[p].afsel[i]) begin
               // codes beyond the wired functions leave the pin idle
               if (code < GP_MUX_W'(GP_ALT_N)) begin
                  drv = alt_out_i[p][i][code[1:0]];  // [RULE6]
                  en  = alt_oe_i[p][i][code[1:0]];
               end else begin
                  drv = 1'b0;
                  en  = 1'b0;
               end
            end else begin
               drv = st_ff.port[p].data[i];  // [RULE13]
               en  = st_ff.port[p].dir[i];
            end
            en = en & st_ff.port[p].digital_enable_reg[i];  // [RULE5]
            if (st_ff.port[p].odr[i]) begin
               // open drain only ever pulls low
               pin_out_o[p][i] = 1'b0;  // [RULE11]
               pin_oe_o[p][i]  = en & ~drv;
            end else begin
               pin_out_o[p][i] = drv;
               pin_oe_o[p][i]  = en;
            end
            alt_in_o[p][i] = st_ff.port[p].afsel[i] & st_ff.port[p].digital_enable_reg[i]
                           & st_ff.port[p].sync2[i];  // [RULE6] [RULE5]
         end
      end
   end

endmodule

// ==== src/gp_pkg.sv ====
package gp_pkg;

   // ==========================================================
   // geometry
   localparam int GP_PORTS   = 7;
   localparam int GP_PINS    = 8;
   localparam int GP_ADDR_W  = 15;
   localparam int GP_MUX_W   = 4;
   localparam int GP_ALT_N   = 4;
   localparam int GP_PSEL_HI = 14;
   localparam int GP_PSEL_LO = 12;
   localparam int GP_MASK_HI = 9;
   localparam int GP_MASK_LO = 2;

   // ==========================================================
   // register offsets inside one port window (byte addresses)
   localparam logic [11:0] GP_OFS_DATA_LAST = 12'h3fc;
   localparam logic [11:0] GP_OFS_DIR       = 12'h400;
   localparam logic [11:0] GP_OFS_ISENSE    = 12'h404;
   localparam logic [11:0] GP_OFS_IBOTH     = 12'h408;
   localparam logic [11:0] GP_OFS_IEVENT    = 12'h40c;
   localparam logic [11:0] GP_OFS_IMASK     = 12'h410;
   localparam logic [11:0] GP_OFS_RAWST     = 12'h414;
   localparam logic [11:0] GP_OFS_MSKST     = 12'h418;
   localparam logic [11:0] GP_OFS_ICLR      = 12'h41c;
   localparam logic [11:0] GP_OFS_AFSEL     = 12'h420;
   localparam logic [11:0] GP_OFS_DR2       = 12'h500;
   localparam logic [11:0] GP_OFS_DR4       = 12'h504;
   localparam logic [11:0] GP_OFS_DR8       = 12'h508;
   localparam logic [11:0] GP_OFS_ODR       = 12'h50c;
   localparam logic [11:0] GP_OFS_PUR       = 12'h510;
   localparam logic [11:0] GP_OFS_PDR       = 12'h514;
   localparam logic [11:0] GP_OFS_SLR       = 12'h518;
   localparam logic [11:0] GP_OFS_DIG_EN    = 12'h51c;
   localparam logic [11:0] GP_OFS_PCTL      = 12'h52c;

   // ==========================================================
   // reset values
   localparam int           GP_PORT_A        = 0;
   localparam int           GP_PORT_C        = 2;
   localparam logic [7:0]   GP_RST_ZERO      = 8'h00;
   localparam logic [7:0]   GP_RST_DR2       = 8'hff;
   localparam logic [7:0]   GP_RST_A_AF      = 8'h3f;
   localparam logic [31:0]  GP_RST_A_PCTL    = 32'h0011_1111;
   localparam logic [7:0]   GP_RST_C_AF      = 8'h0f;
   localparam logic [7:0]   GP_RST_C_PUR     = 8'h0f;
   localparam logic [31:0]  GP_RST_C_PCTL    = 32'h0000_3333;

   // ==========================================================
   // types
   typedef struct packed {
      logic [7:0]  data;
      logic [7:0]  dir;
      logic [7:0]  isense;
      logic [7:0]  iboth;
      logic [7:0]  ievent;
      logic [7:0]  imask;
      logic [7:0]  rawst;
      logic [7:0]  afsel;
      logic [7:0]  dr2;
      logic [7:0]  dr4;
      logic [7:0]  dr8;
      logic [7:0]  odr;
      logic [7:0]  pur;
      logic [7:0]  pdr;
      logic [7:0]  slr;
      logic [7:0]  digital_enable_reg;
      logic [31:0] pctl;
      logic [7:0]  sync1;
      logic [7:0]  sync2;
      logic [7:0]  prev;
   } gp_port_t;

   typedef struct packed {
      gp_port_t [GP_PORTS-1:0] port;
      logic [31:0]             rdata;
   } gp_state_t;

   typedef struct packed {
      logic [7:0] pull_up;
      logic [7:0] pull_down;
      logic [7:0] open_drain;
      logic [7:0] drive_2ma;
      logic [7:0] drive_4ma;
      logic [7:0] drive_8ma;
      logic [7:0] slew_ctl;
      logic [7:0] analog_sel;
   } gp_pad_t;

   function automatic gp_state_t gp_reset_state();
      gp_state_t s;
      s = '0;
      for (int p = 0; p < GP_PORTS; p++) begin
         s.port[p].dr2 = GP_RST_DR2;
      end
      s.port[GP_PORT_A].afsel = GP_RST_A_AF;
      s.port[GP_PORT_A].digital_enable_reg = GP_RST_A_AF;
      s.port[GP_PORT_A].pctl  = GP_RST_A_PCTL;
      s.port[GP_PORT_C].afsel = GP_RST_C_AF;
      s.port[GP_PORT_C].digital_enable_reg = GP_RST_C_AF;
      s.port[GP_PORT_C].pur   = GP_RST_C_PUR;
      s.port[GP_PORT_C].pctl  = GP_RST_C_PCTL;
      return s;
   endfunction

   localparam gp_state_t GP_RST_STATE = gp_reset_state();

endpackage

// ==== test/gp_pin_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// pads and peripherals outside the port bank
module gp_pin_model
   import gp_pkg::*;
(
   input  logic                                           clk_i,
   input  logic                                           reset_i,
   input  logic [GP_PORTS-1:0][GP_PINS-1:0]               pin_out_i,
   input  logic [GP_PORTS-1:0][GP_PINS-1:0]               pin_oe_i,
   input  gp_pad_t [GP_PORTS-1:0]                         pad_i,
   input  logic [GP_PORTS-1:0][GP_PINS-1:0]               ext_i,
   output logic [GP_PORTS-1:0][GP_PINS-1:0]               pin_in_o,
   output logic [GP_PORTS-1:0][GP_PINS-1:0][GP_ALT_N-1:0] alt_out_o,
   output logic [GP_PORTS-1:0][GP_PINS-1:0][GP_ALT_N-1:0] alt_oe_o
);
   logic [15:0] cnt_ff;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_ff <= 16'h5a3c;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end
   // every mux code sees its own moving bit, so a wrong code shows at once
   assign alt_out_o = {14{cnt_ff}};
   assign alt_oe_o  = {14{~cnt_ff}};
   // wire level: driver wins, then pulls, then the outside world
   always_comb begin
      for (int p = 0; p < GP_PORTS; p++) begin
         pin_in_o[p] = (pin_oe_i[p] & pin_out_i[p])
                     | (~pin_oe_i[p] & (pad_i[p].pull_up | (~pad_i[p].pull_down & ext_i[p])));
      end
   end
endmodule

// ==== test/gp_port_bank_chk.sv ====
`timescale 1ns/10ps
// ==========================================================
// port-level checks of the port bank
module gp_chk
   import gp_pkg::*;
(
   input logic                                clk_i,
   input logic                                reset_i,
   input logic [GP_ADDR_W-1:0]                addr_i,
   input logic [31:0]                         wdata_i,
   input logic                                wr_i,
   input logic                                rd_i,
   input logic [31:0]                         rdata_o,
   input logic [GP_PORTS-1:0]                 irq_o,
   input logic [GP_PORTS-1:0][GP_PINS-1:0]    pin_in_i,
   input logic [GP_PORTS-1:0][GP_PINS-1:0]    pin_oe_o,
   input logic [GP_PORTS-1:0][GP_PINS-1:0]    alt_in_o,
   input gp_pad_t [GP_PORTS-1:0]              pad_o
);
   logic leak_w;
   logic pad_bad_w;
   always_comb begin
      leak_w    = 1'b0;
      pad_bad_w = 1'b0;
      for (int p = 0; p < GP_PORTS; p++) begin
         leak_w    = leak_w | (|((pin_oe_o[p] | alt_in_o[p]) & pad_o[p].analog_sel));
         pad_bad_w = pad_bad_w | (|(pad_o[p].slew_ctl & ~pad_o[p].drive_8ma))
                   | (|(pad_o[p].drive_2ma & pad_o[p].drive_4ma))
                   | (|((pad_o[p].drive_2ma | pad_o[p].drive_4ma) & pad_o[p].drive_8ma))
                   | (|(pad_o[p].pull_up & pad_o[p].pull_down));
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   a_read_slot: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside its slot");
   a_unmapped_zero: assert property (rd_i && addr_i[14:12] == 3'h7 |=> rdata_o == 32'h0)
      else $error("unmapped port returned data");
   a_mask_gates_irq: assert property (wr_i && addr_i[14:12] != 3'h7 && addr_i[11:0] == GP_OFS_IMASK
      && wdata_i[7:0] == 8'h00 |=> !irq_o[$past(addr_i[14:12])]) else $error("masked port interrupt");
   a_analog_isolated: assert property (!leak_w)
      else $error("digital path active on disabled pin");
   a_pad_coherent: assert property (!pad_bad_w)
      else $error("pad controls inconsistent");
   a_reset_defaults: assert property ($fell(reset_i) |-> pad_o[GP_PORT_C].pull_up == 8'h0f
      && pad_o[GP_PORT_A].analog_sel == 8'hc0 && pad_o[1].analog_sel == 8'hff && irq_o == 7'h00)
      else $error("pad defaults wrong after reset");
   // the synchroniser restarts from zero, so the window must begin after reset
   a_sync_settle: assert property ((!reset_i && !wr_i && $stable(pin_in_i)) [*4] |-> $stable(alt_in_o))
      else $error("peripheral input moved without pin change");
   a_irq_steady: assert property ((!reset_i && !wr_i && $stable(pin_in_i)) [*4] |-> $stable(irq_o))
      else $error("interrupt moved without cause");
endmodule

bind gp_port_bank gp_chk i_gp_chk (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .pin_in_i(pin_in_i), .pin_oe_o(pin_oe_o),
   .alt_in_o(alt_in_o), .pad_o(pad_o));

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
   import gp_pkg::*;
   logic                                           clk_i = 1'b0;
   logic                                           reset_i, wr_i, rd_i, rd_d;
   logic [GP_ADDR_W-1:0]                           addr_i;
   logic [31:0]                                    wdata_i, rdata_o, seed = 32'h0000_e126, x;
   logic [GP_PORTS-1:0]                            irq_o;
   logic [GP_PORTS-1:0][GP_PINS-1:0]               pin_in, pin_out, pin_oe, alt_in, ext;
   logic [GP_PORTS-1:0][GP_PINS-1:0][GP_ALT_N-1:0] alt_out, alt_oe;
   gp_pad_t [GP_PORTS-1:0]                         pad;
   logic [31:0]                                    exp_q[$];
   logic [7:0]                                     d, m, v;
   logic [5:0]                                     tbl [6] = '{6'h13, 6'h22, 6'h21, 6'h25, 6'h1b, 6'h18};
   int                                             n_errors = 0, num_checks = 0;
   always #12.5 clk_i = ~clk_i;
   gp_port_bank i_gp_port_bank (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .pin_in_i(pin_in), .pin_out_o(pin_out),
      .pin_oe_o(pin_oe), .alt_out_i(alt_out), .alt_oe_i(alt_oe), .alt_in_o(alt_in), .pad_o(pad));
   gp_pin_model i_gp_pin_model (.clk_i(clk_i), .reset_i(reset_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
      .pad_i(pad), .ext_i(ext), .pin_in_o(pin_in), .alt_out_o(alt_out), .alt_oe_o(alt_oe));
   // ==========================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic bus(input logic w, input logic r, input logic [2:0] p, input logic [11:0] o, input logic [31:0] dt);
      wr_i    <= w;
      rd_i    <= r;
      addr_i  <= {p, o};
      wdata_i <= dt;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [2:0] p, input logic [11:0] o, input logic [31:0] dt);
      bus(1'b1, 1'b0, p, o, dt);
   endtask
   task automatic rd(input logic [2:0] p, input logic [11:0] o, input logic [31:0] want);
      exp_q.push_back(want);
      bus(1'b0, 1'b1, p, o, 32'h0);
   endtask
   task automatic idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 3'h0, 12'h0, 32'h0);
   endtask
   task automatic complete_run();
      if (exp_q.size() != 0) n_errors++;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // read data watcher: the result stands only in the cycle after the strobe
   always @(posedge clk_i) rd_d <= rd_i;
   always @(negedge clk_i) begin
      if (rd_d === 1'b1) begin
         if (exp_q.size() == 0) check("read with no note", 32'h1, 32'h0);
         else check("read data", rdata_o, exp_q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      complete_run();
   end
   // ==========================================================
   // scenarios
   initial begin
      reset_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = '0; wdata_i = '0; ext = '0;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int p = 0; p < GP_PORTS; p++) begin
         v = (p == 0) ? 8'h3f : (p == 2) ? 8'h0f : 8'h00;
         rd(p[2:0], GP_OFS_AFSEL, {24'h0, v});
         rd(p[2:0], GP_OFS_DIG_EN, {24'h0, v});
         rd(p[2:0], GP_OFS_PUR, (p == 2) ? 32'h0000_000f : 32'h0);
         rd(p[2:0], GP_OFS_PDR, 32'h0);
         rd(p[2:0], GP_OFS_PCTL, (p == 0) ? 32'h0011_1111 : (p == 2) ? 32'h3333 : 32'h0);
      end
      $display("test defaults done");
      wr(3'h3, GP_OFS_DIG_EN, 32'hff);
      wr(3'h3, GP_OFS_DIR, 32'hff);
      wr(3'h3, GP_OFS_DATA_LAST, 32'h0);
      v = 8'h00;
      // random masked writes, one per cycle
      for (int i = 0; i < 8; i++) begin
         x = rnd();
         d = x[7:0];
         m = x[15:8];
         wr(3'h3, {2'b00, m, 2'b00}, {24'h0, d});
         v = (v & ~m) | (d & m);
         #1 check("pin drive", {24'h0, pin_out[3]}, {24'h0, v});
      end
      check("pin enable", {24'h0, pin_oe[3]}, 32'hff);
      wr(3'h3, GP_OFS_DATA_LAST, 32'h0);
      wr(3'h3, 12'h098, 32'heb);
      rd(3'h3, 12'h0c4, 32'h20);
      rd(3'h3, GP_OFS_DATA_LAST, 32'h22);
      wr(3'h3, GP_OFS_ODR, 32'hff);
      #1 check("open drain", {16'h0, pin_out[3], pin_oe[3]}, 32'h00dd);
      $display("test data mask done");
      ext[4] <= 8'ha5;
      wr(3'h4, GP_OFS_DIG_EN, 32'h0f);
      idle(4);
      rd(3'h4, GP_OFS_DATA_LAST, 32'h05);
      #1 check("peripheral input", {24'h0, alt_in[4]}, 32'h0);
      $display("test input capture done");
      wr(3'h5, GP_OFS_DIG_EN, 32'hff);
      foreach (tbl[k]) begin
         ext[5] <= {7'h0, tbl[k][5]};
         wr(3'h5, GP_OFS_ISENSE, {31'h0, tbl[k][3]});
         wr(3'h5, GP_OFS_IBOTH, {31'h0, tbl[k][2]});
         wr(3'h5, GP_OFS_IEVENT, {31'h0, tbl[k][1]});
         idle(3);
         wr(3'h5, GP_OFS_ICLR, 32'hff);
         wr(3'h5, GP_OFS_IMASK, 32'h01);
         ext[5] <= {7'h0, tbl[k][4]};
         idle(6);
         #1 check("port interrupt", {31'h0, irq_o[5]}, {31'h0, tbl[k][0]});
         wr(3'h5, GP_OFS_IMASK, 32'h00);
         #1 check("masked interrupt", {31'h0, irq_o[5]}, 32'h0);
         wr(3'h5, GP_OFS_ICLR, 32'hff);
         rd(3'h5, GP_OFS_RAWST, {31'h0, tbl[k][0] & tbl[k][3]});
      end
      $display("test interrupts done");
      wr(3'h6, GP_OFS_AFSEL, 32'h03);
      wr(3'h6, GP_OFS_DIG_EN, 32'h03);
      wr(3'h6, GP_OFS_PCTL, 32'h02);
      #1 check("alt route", {28'h0, pin_oe[6][1:0], pin_out[6][1:0]},
         {28'h0, alt_oe[6][1][0], alt_oe[6][0][2], alt_out[6][1][0], alt_out[6][0][2]});
      wr(3'h6, GP_OFS_DIG_EN, 32'h01);
      wr(3'h6, GP_OFS_DR8, 32'h01);
      wr(3'h6, GP_OFS_SLR, 32'h01);
      #1 check("pad", {pad[6].analog_sel, pad[6].drive_2ma, pad[6].drive_8ma, pad[6].slew_ctl},
         32'hfefe0101);
      rd(3'h6, GP_OFS_DR2, 32'hfe);
      rd(3'h7, GP_OFS_DIR, 32'h0);
      wr(3'h2, GP_OFS_PUR, 32'h0);
      idle(2);
      $display("test alternate function done");
      reset_i <= 1'b1;
      idle(2);
      reset_i <= 1'b0;
      rd(3'h2, GP_OFS_PUR, 32'h0f);
      rd(3'h6, GP_OFS_AFSEL, 32'h0);
      idle(2);
      $display("test second reset done");
      complete_run();
   end
endmodule
